//--- common/umsl_pkg.sv
// package: constants for the modem signal logic block
// Function
// (R1) ring status bit 6 reads as the complement of the ring pin level.
// (R2) ring-rise flag, bit 2, sets on a low-to-high ring pin change.
// (R3) interrupt raised when ring-rise flag sets and modem status interrupts enabled.
// (R4) request-to-send pin low when control bit 1 is one, else high.
// (R5) reset forces request-to-send pin to its inactive high level.
// (R6) loop mode holds request-to-send inactive regardless of control bit.
// (R7) reading the modem status register clears the ring-rise flag.
package umsl_pkg;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] STAT_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] MCR_OFS = 4'h4;
  localparam logic [ADDR_W-1:0] IER_OFS = 4'h8;
  localparam logic [ADDR_W-1:0] IST_OFS = 4'hC;
  localparam int RING_LVL_BIT = 6;
  localparam int RING_RISE_BIT = 2;
  localparam int RTS_BIT = 1;
  localparam int LOOP_BIT = 4;
  localparam int MSI_EN_BIT = 0;
  localparam logic [7:0] MCR_RST = 8'h00;
  localparam logic [7:0] IER_RST = 8'h00;
  localparam logic [7:0] IST_RST = 8'h00;
  typedef enum logic [1:0] {
    UMSL_IDLE = 2'b00,
    UMSL_RESP = 2'b01
  } umsl_bus_st_t;
endpackage

//--- verilog/umsl_sync.sv
// two-stage synchroniser for a pin input
`timescale 1ns/1ps
module umsl_sync (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta_r;
  always_ff @(posedge core_clk_i) begin
    // idle pin level is high, so reset to one avoids a false edge
    if (srst_i) begin
      meta_r <= 1'b1;
      q_o <= 1'b1;
    end else if (ce_i) begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule

//--- verilog/umsl_edge.sv
// rising edge detector with registered previous level
`timescale 1ns/1ps
module umsl_edge (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic lvl_i,
  output logic rise_o
);
  logic prev_r;
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      prev_r <= 1'b1;
    end else if (ce_i) begin
      prev_r <= lvl_i;
    end
  end
  assign rise_o = ce_i & lvl_i & ~prev_r;
endmodule

//--- verilog/umsl_top.sv
// modem handshake logic: ring status, ring-rise event, rts control
//
// Local design decisions: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
module umsl_top (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic [umsl_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic irq_o,
  input wire logic ring_indicate_in_i,
  output logic rts_n_o
);
  import umsl_pkg::*;

  logic ring_s;
  logic ring_rise;
  umsl_bus_st_t st_r;
  umsl_bus_st_t st_nxt;
  logic [7:0] mcr_r;
  logic [7:0] ier_r;
  logic [7:0] ist_r;
  logic ring_rise_flag_r;
  logic [31:0] rdata_nxt;

  umsl_sync umsl_sync_inst (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .d_i(ring_indicate_in_i),
    .q_o(ring_s)
  );

  umsl_edge umsl_edge_inst (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .lvl_i(ring_s),
    .rise_o(ring_rise)
  ); // [R2]

  // one wait cycle, then the answer: request accepted in UMSL_RESP
  wire req = avs_read_i | avs_write_i;
  wire accept = (st_r == UMSL_RESP) & req & ce_i;
  wire wr_acc = accept & avs_write_i & avs_byteenable_i[0];
  wire rd_acc = accept & avs_read_i;
  wire wr_mcr = wr_acc & (avs_address_i == MCR_OFS);
  wire wr_ier = wr_acc & (avs_address_i == IER_OFS);
  wire rd_stat = rd_acc & (avs_address_i == STAT_OFS);
  wire rd_ist = rd_acc & (avs_address_i == IST_OFS);

  wire [7:0] stat_val = {1'b0, ~ring_s, 3'b000, ring_rise_flag_r, 2'b00}; // [R1]
  wire [7:0] ist_set = {7'h00, ring_rise}; // event: ring-rise flag set
  // read data is snapshotted one edge before the clear: clear only what was
  // reported, so an edge landing in between is kept; set wins over clear
  wire stat_clr = rd_stat & avs_readdata_o[RING_RISE_BIT];
  wire flag_nxt = ring_rise | (ring_rise_flag_r & ~stat_clr); // [R2] [R7]
  wire [7:0] ist_clr = rd_ist ? avs_readdata_o[7:0] : 8'h00;
  wire [7:0] ist_nxt = ist_set | (ist_r & ~ist_clr);
  wire irq_nxt = |(ist_nxt & ier_r); // [R3]
  wire [7:0] mcr_nxt = wr_mcr ? avs_writedata_i[7:0] : mcr_r;
  // loop mode forces inactive; control bit one drives the pin low
  wire rts_nxt = ~(mcr_nxt[RTS_BIT] & ~mcr_nxt[LOOP_BIT]); // [R4] [R6]

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (avs_address_i)
      STAT_OFS: rdata_nxt = {24'h000000, stat_val};
      MCR_OFS: rdata_nxt = {24'h000000, mcr_r};
      IER_OFS: rdata_nxt = {24'h000000, ier_r};
      IST_OFS: rdata_nxt = {24'h000000, ist_r};
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      UMSL_IDLE: st_nxt = req ? UMSL_RESP : UMSL_IDLE;
      UMSL_RESP: st_nxt = UMSL_IDLE;
      default: st_nxt = UMSL_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      st_r <= UMSL_IDLE;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
    end else if (ce_i) begin
      st_r <= st_nxt;
      // waitrequest low only during the one answer cycle
      avs_waitrequest_o <= ~((st_r == UMSL_IDLE) & req);
      avs_readdata_o <= ((st_r == UMSL_IDLE) & avs_read_i) ? rdata_nxt : 32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      mcr_r <= MCR_RST;
      ier_r <= IER_RST;
      ist_r <= IST_RST;
      ring_rise_flag_r <= 1'b0;
      irq_o <= 1'b0;
      rts_n_o <= 1'b1; // [R5]
    end else if (ce_i) begin
      mcr_r <= mcr_nxt;
      if (wr_ier) begin
        ier_r <= avs_writedata_i[7:0];
      end
      ist_r <= ist_nxt;
      ring_rise_flag_r <= flag_nxt;
      irq_o <= irq_nxt;
      rts_n_o <= rts_nxt;
    end
  end
endmodule

//--- tb/umsl_sva.sv
// checker: port properties of the modem signal logic
`timescale 1ns/1ps
module umsl_sva (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic [umsl_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic irq_o,
  input wire logic ring_indicate_in_i,
  input wire logic rts_n_o
);
  import umsl_pkg::*;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  wire ack = !avs_waitrequest_o;
  wire req = avs_read_i || avs_write_i;
  wire mcr_wr = ack && avs_write_i && avs_byteenable_i[0] && avs_address_i == MCR_OFS;
  // a control write taken at this edge
  sequence s_mcr_write;
    mcr_wr;
  endsequence
  // the answer seen here was snapshotted from the pin three edges back
  a_ring_status: assert property (ack && $past(avs_read_i && avs_address_i == STAT_OFS)
    |-> avs_readdata_o[RING_LVL_BIT] == !$past(ring_indicate_in_i, 3))
    else $error("ring status bit");
  a_rts_write: assert property (s_mcr_write
    |=> rts_n_o == !($past(avs_writedata_i[RTS_BIT]) && !$past(avs_writedata_i[LOOP_BIT])))
    else $error("rts level");
  a_rts_steady: assert property ($changed(rts_n_o) && !$past(srst_i) |-> $past(mcr_wr))
    else $error("rts moved without write");
  a_read_idle: assert property (!ack |-> avs_readdata_o == 32'h0000_0000)
    else $error("read data outside answer");
  a_reset_idle: assert property ($fell(srst_i) |-> rts_n_o && !irq_o)
    else $error("reset levels");
  a_wait_one: assert property (req && !ack && $past(!ack) |=> ack) else $error("no answer");
  a_wait_pulse: assert property (ack |=> !ack) else $error("long answer");
endmodule
bind umsl_top umsl_sva umsl_sva_inst (
  .core_clk_i(core_clk_i),
  .srst_i(srst_i),
  .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o),
  .irq_o(irq_o),
  .ring_indicate_in_i(ring_indicate_in_i),
  .rts_n_o(rts_n_o)
);

//--- tb/umsl_modem.sv
// partner model: modem driving the ring pin
`timescale 1ns/1ps
module umsl_modem (
  input wire logic core_clk_i,
  input wire logic ring_i,
  output logic ring_n_o
);
  // pin moves off the sampling edge, as an async line would
  initial ring_n_o = 1'b1;
  always @(negedge core_clk_i) ring_n_o <= !ring_i;
endmodule

//--- tb/uart_modem_signal_logic_tb.sv
// testbench: ring status, interrupt and request-to-send
`timescale 1ns/1ps
module uart_modem_signal_logic_tb;
  logic clk = 0, rst = 1, rd = 0, wr = 0, ring = 0, ce = 1;
  logic [3:0] ad = 0;
  logic [31:0] wd = 0, q, rdat;
  logic wrq, irq, rts_n, pin;
  int fail_count = 0, total_checks = 0, cyc = 0;
  initial forever #10 clk = ~clk;
  umsl_top umsl_top_inst (.core_clk_i(clk), .srst_i(rst), .ce_i(ce), .avs_address_i(ad),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wrq), .irq_o(irq),
    .ring_indicate_in_i(pin), .rts_n_o(rts_n));
  umsl_modem umsl_modem_inst (.core_clk_i(clk), .ring_i(ring), .ring_n_o(pin));
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    {rd, wr, ad, wd} <= {!w, w, a, 24'h0, d};
    do @(posedge clk); while (wrq !== 1'b0);
    q = rdat;
    {rd, wr} <= 2'b0;
    @(posedge clk);
  endtask
  task automatic pulse();
    ring <= 1;
    repeat (6) @(posedge clk);
    ring <= 0;
    repeat (6) @(posedge clk);
  endtask
  task automatic t_ring();
    pulse();
    chk("irq", 32'h0, irq);
    bus(0, 4'h0, 8'h00);
    chk("status", 32'h04, q);
    bus(0, 4'h0, 8'h00);
    chk("status", 32'h00, q);
    bus(0, 4'hC, 8'h00);
    chk("irq status", 32'h01, q);
    bus(1, 4'h8, 8'h01);
    ring <= 1;
    repeat (6) @(posedge clk);
    bus(0, 4'h0, 8'h00);
    chk("status", 32'h40, q);
    ring <= 0;
    repeat (6) @(posedge clk);
    chk("irq", 32'h1, irq);
    bus(0, 4'hC, 8'h00);
    chk("irq status", 32'h01, q);
    chk("irq", 32'h0, irq);
    bus(0, 4'h0, 8'h00);
    chk("status", 32'h04, q);
    $display("ring test done");
  endtask
  task automatic t_hold();
    ce <= 0;
    pulse();
    ce <= 1;
    @(posedge clk);
    bus(0, 4'h0, 8'h00);
    chk("frozen status", 32'h00, q);
    $display("hold test done");
  endtask
  task automatic t_rts();
    for (int i = 0; i < 4; i++) begin
      bus(1, 4'h4, {3'h0, i[1], 2'h0, i[0], 1'b0});
      chk("rts_n", !(i[0] && !i[1]), rts_n);
    end
    bus(0, 4'h4, 8'h00);
    chk("control", 32'h12, q);
    bus(1, 4'h2, 8'h02);
    bus(0, 4'h4, 8'h00);
    chk("control", 32'h12, q);
    bus(0, 4'h2, 8'h00);
    chk("unmapped", 32'h00, q);
    bus(1, 4'h4, 8'h02);
    chk("rts_n", 32'h0, rts_n);
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    chk("rts_n", 32'h1, rts_n);
    bus(0, 4'h4, 8'h00);
    chk("control", 32'h00, q);
    $display("rts test done");
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      close_out();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 0;
    t_ring();
    t_hold();
    t_rts();
    close_out();
  end
endmodule
